// *** hw/hbsc_flags.v ***
// hbsc_flags.v: bank of sticky fault flags with one shared clear pulse.
// assumes set and clear are on clk_sys; a set in the clear cycle wins.
`timescale 1ns/1ps
module hbsc_flags #(
    parameter                 W = 1
) (
    // clock and reset
    input  wire               clk_sys,
    input  wire               arst_n,
    // events and clear
    input  wire [W-1:0]       set,
    input  wire               clr,
    // flags
    output wire [W-1:0]       q
);
    reg  [W-1:0]              flag_q;
    wire [W-1:0]              flag_d;

    // set beats clear in the same cycle
    assign flag_d = (flag_q & ~{W{clr}}) | set;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= {W{1'b0}};
        end else begin
            flag_q <= flag_d;
        end
    end

    assign q = flag_q;
endmodule

// *** hw/hbsc_sync.v ***
// hbsc_sync.v: two-flop synchroniser for a bundle of asynchronous levels.
// assumes each bit is an independent level; reset value is a parameter.
`timescale 1ns/1ps
module hbsc_sync #(
    parameter                 W       = 1,
    parameter [W-1:0]         RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input  wire               clk_sys,
    input  wire               arst_n,
    // levels
    input  wire [W-1:0]       d_async,
    output wire [W-1:0]       q
);
    reg  [W-1:0]              meta_q;
    reg  [W-1:0]              sync_q;

    // first stage feeds only the second stage
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d_async;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// *** hw/hbsc_top.v ***
// hbsc_top.v: serial control and status port of a six half-bridge driver.
// assumes the link pins and the analog detector levels are asynchronous to
// clk_sys and that the serial clock is far slower than clk_sys.
`timescale 1ns/1ps
`include "hbsc_defines.vh"
module hbsc_top #(
    parameter                 SHORT_LONG_CYC  = `HBSC_SHORT_LONG_CYC,
    parameter                 SHORT_SHORT_CYC = `HBSC_SHORT_SHORT_CYC
) (
    // clock and reset
    input  wire               clk_sys,
    input  wire               arst_n,
    // serial link pins
    input  wire               sclk,
    input  wire               cs_n,
    input  wire               serial_in,
    output wire               serial_out,
    output wire               serial_out_oe,
    // hardware standby pin
    input  wire               hard_standby_pin,
    // detector levels from the analog section
    input  wire               temp_prewarn_in,
    input  wire               overtemp_in,
    input  wire               load_supply_low_in,
    input  wire [11:0]        open_load_in,
    input  wire [11:0]        current_limit_in,
    // output stage controls
    output wire [5:0]         low_side_on,
    output wire [5:0]         high_side_on,
    output wire               open_load_check_n,
    output wire               short_delay_select,
    output wire               standby,
    output wire               status_clear_request
);
    localparam                NSYNC = 31;
    localparam [NSYNC-1:0]    SYNC_RST = {{29{1'b0}}, 1'b1, 1'b0};

    // positions of each level inside the synchroniser bundle
    localparam                SI_SCLK     = 0;
    localparam                SI_CS_N     = 1;
    localparam                SI_DATA     = 2;
    localparam                SI_STANDBY  = 3;
    localparam                SI_PREWARN  = 4;
    localparam                SI_OVERTEMP = 5;
    localparam                SI_SUPPLY   = 6;
    localparam                SI_OPEN     = 7;
    localparam                SI_LIMIT    = 19;

    // flag bank: twelve short trips, then supply fail and overtemperature
    localparam                FL_SUPPLY   = 12;
    localparam                FL_OT       = 13;

    // synchronised pins and detector levels
    wire [NSYNC-1:0]          sync_q;
    wire                      sclk_s;
    wire                      cs_n_s;
    wire                      serial_in_s;
    wire                      hard_standby_pin_s;
    wire                      prewarn_s;
    wire                      overtemp_s;
    wire                      supply_low_s;
    wire [11:0]               open_load_s;
    wire [11:0]               limit_s;

    // edge detection state
    reg                       sclk_d_q;
    reg                       cs_n_d_q;
    wire                      sclk_rise;
    wire                      sclk_fall;
    wire                      cs_fall;
    wire                      cs_rise;
    wire                      in_frame;

    // frame state
    reg  [15:0]               rx_q;
    reg  [15:0]               tx_q;
    reg  [`HBSC_CNT_W-1:0]    bit_cnt_q;
    reg                       last_in_q;
    reg                       oe_q;
    reg  [15:0]               ctrl_q;
    reg                       clear_q;

    // protection and status
    wire [13:0]               flag_set;
    wire [13:0]               flag_q;
    wire [11:0]               short_trip;
    wire                      short_any;
    wire                      ot_flag;
    wire                      supply_flag;
    wire                      run_ok;
    wire                      drive_en;
    wire [11:0]               sw_cmd;
    reg  [11:0]               sw_on_q;
    reg  [15:0]               status_w;
    reg                       standby_q;

    // every input from outside the clock domain passes two flops
    hbsc_sync #(
        .W       (NSYNC),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d_async ({current_limit_in, open_load_in, load_supply_low_in, overtemp_in,
                   temp_prewarn_in, hard_standby_pin, serial_in, cs_n, sclk}),
        .q       (sync_q)
    );

    assign sclk_s             = sync_q[SI_SCLK];
    assign cs_n_s             = sync_q[SI_CS_N];
    assign serial_in_s        = sync_q[SI_DATA];
    assign hard_standby_pin_s = sync_q[SI_STANDBY];
    assign prewarn_s          = sync_q[SI_PREWARN];
    assign overtemp_s         = sync_q[SI_OVERTEMP];
    assign supply_low_s       = sync_q[SI_SUPPLY];
    assign open_load_s        = sync_q[SI_OPEN+11:SI_OPEN];
    assign limit_s            = sync_q[SI_LIMIT+11:SI_LIMIT];

    // edge finders on the synchronised link lines
    // reset values equal the idle levels, so no false edge follows reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d_q <= 1'b0;
            cs_n_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            cs_n_d_q <= cs_n_s;
        end
    end

    // one rule for what counts as an edge on a synchronised line
    function edge_seen;
        input                 prev;
        input                 cur;
        input                 rising;
        begin
            if (rising) begin
                edge_seen = ~prev & cur;
            end else begin
                edge_seen = prev & ~cur;
            end
        end
    endfunction

    assign cs_fall   = edge_seen(cs_n_d_q, cs_n_s, 1'b0);
    assign cs_rise   = edge_seen(cs_n_d_q, cs_n_s, 1'b1);
    assign in_frame  = ~cs_n_d_q & ~cs_n_s;
    assign sclk_fall = in_frame & edge_seen(sclk_d_q, sclk_s, 1'b0);
    assign sclk_rise = in_frame & edge_seen(sclk_d_q, sclk_s, 1'b1);

    // status word assembly
    always @* begin
        status_w = 16'h0000;
        status_w[`HBSC_ST_PREWARN] = prewarn_s;
        status_w[`HBSC_ST_SHORT]   = short_any;
        status_w[`HBSC_ST_STANDBY] = ~run_ok;
        status_w[`HBSC_ST_SUPPLY]  = supply_flag;
        // normal mode shows the real drive, after standby and fault gating
        status_w[`HBSC_ST_SW_HI:`HBSC_ST_SW_LO] = sw_on_q;
        if (!ctrl_q[`HBSC_CTL_OL_CHECK_N]) begin
            // open load only on outputs that are off
            status_w[`HBSC_ST_SW_HI:`HBSC_ST_SW_LO] = open_load_s & ~sw_on_q;
        end
        // overtemperature overrides every field so the host cannot miss it
        if (ot_flag) begin
            status_w = `HBSC_ALL_ONES;
        end
    end

    // a frame counts only once all sixteen bits have been sampled
    function frame_complete;
        input [`HBSC_CNT_W-1:0] cnt;
        begin
            frame_complete = (cnt == `HBSC_FRAME_BITS);
        end
    endfunction

    // receive shifter and bit counter; idle while deselected
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_q      <= 16'h0000;
            bit_cnt_q <= {`HBSC_CNT_W{1'b0}};
            last_in_q <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_q <= {`HBSC_CNT_W{1'b0}};
        end else if (sclk_fall) begin
            // new bit enters at the top so bit 0 ends at the bottom
            rx_q      <= {serial_in_s, rx_q[15:1]};
            last_in_q <= serial_in_s;
            // a longer frame keeps shifting; the last sixteen bits count
            if (!frame_complete(bit_cnt_q)) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // transmit shifter and output enable
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_q <= 16'h0000;
            oe_q <= 1'b0;
        end else if (cs_fall) begin
            tx_q <= status_w;
            oe_q <= 1'b1;
        end else if (cs_rise) begin
            oe_q <= 1'b0;
        end else if (sclk_rise && bit_cnt_q != {`HBSC_CNT_W{1'b0}}) begin
            // the first rise finds bit 0 already on the line; shifting
            // there would lose it before the host has taken it
            // advance after the first sample; received bits follow for chaining
            tx_q <= {last_in_q, tx_q[15:1]};
        end
    end

    assign serial_out    = tx_q[0];
    assign serial_out_oe = oe_q;

    // control word takes effect only on a complete frame
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q  <= `HBSC_CTL_RESET;
            clear_q <= 1'b0;
        end else begin
            clear_q <= 1'b0;
            // the clear bit leaves only a one-cycle pulse behind
            if (cs_rise && frame_complete(bit_cnt_q)) begin
                ctrl_q  <= rx_q;
                clear_q <= rx_q[`HBSC_CTL_CLEAR];
            end
            // a shorter frame leaves ctrl_q and the flags untouched
        end
    end

    // standby from software bit and hardware pin
    assign run_ok   = ctrl_q[`HBSC_CTL_RUN] & hard_standby_pin_s;
    // undervoltage and overtemperature gate the drive, not the command
    assign drive_en = run_ok & ~ot_flag & ~supply_low_s;
    assign sw_cmd   = ctrl_q[`HBSC_CTL_SW_HI:`HBSC_CTL_SW_LO];

    // standby output registered so the analog section sees a clean level
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            standby_q <= 1'b1;
        end else begin
            standby_q <= ~run_ok;
        end
    end

    // registered switch drive; bit 2k is low side, 2k+1 high side
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sw_on_q <= 12'h000;
        end else begin
            sw_on_q <= sw_cmd & {12{drive_en}} & ~short_trip;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_bridge
            assign low_side_on[g]  = sw_on_q[2*g];
            assign high_side_on[g] = sw_on_q[2*g+1];
        end
    endgenerate

    // short-circuit timers, one per switch, delay picked by control bit
    generate
        for (g = 0; g < `HBSC_NUM_SW; g = g + 1) begin : g_short
            reg  [`HBSC_TMR_W-1:0] tmr_q;
            wire [`HBSC_TMR_W-1:0] limit_cyc;
            wire                   hit;

            assign limit_cyc = ctrl_q[`HBSC_CTL_SHORT_SEL] ?
                               SHORT_LONG_CYC[`HBSC_TMR_W-1:0] :
                               SHORT_SHORT_CYC[`HBSC_TMR_W-1:0];
            // prewarning during a short trips at once
            assign hit = sw_on_q[g] & limit_s[g] &
                         (prewarn_s | (tmr_q >= limit_cyc - 21'h000001));
            assign flag_set[g] = hit;

            // the count restarts whenever the current limit lets go
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    tmr_q <= {`HBSC_TMR_W{1'b0}};
                end else if (sw_on_q[g] & limit_s[g] & ~hit) begin
                    tmr_q <= tmr_q + 21'h000001;
                end else begin
                    tmr_q <= {`HBSC_TMR_W{1'b0}};
                end
            end
        end
    endgenerate

    // supply fail and overtemperature events
    assign flag_set[FL_SUPPLY] = supply_low_s;
    assign flag_set[FL_OT]     = overtemp_s;

    // sticky faults cleared by a written clear bit
    // a set in the clear cycle survives, so no event is lost
    hbsc_flags #(
        .W       (14)
    ) u_flags (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .set     (flag_set),
        .clr     (clear_q),
        .q       (flag_q)
    );

    assign short_trip  = flag_q[11:0];
    assign short_any   = |flag_q[11:0];
    assign supply_flag = flag_q[FL_SUPPLY];
    assign ot_flag     = flag_q[FL_OT];

    // control fields straight to the analog section; standby_q and clear_q registered
    assign open_load_check_n    = ctrl_q[`HBSC_CTL_OL_CHECK_N];
    assign short_delay_select   = ctrl_q[`HBSC_CTL_SHORT_SEL];
    assign standby              = standby_q;
    assign status_clear_request = clear_q;
endmodule

// *** include/hbsc_defines.vh ***
// hbsc_defines.vh: constants of the half-bridge serial control block.
// assumes inclusion by bare name from the top design file of the block only.
`ifndef HBSC_DEFINES_VH
`define HBSC_DEFINES_VH

// frame and word geometry
`define HBSC_WORD_W            16
`define HBSC_NUM_SW            12
`define HBSC_CNT_W             5
`define HBSC_FRAME_BITS        5'h10

// control word field positions
`define HBSC_CTL_CLEAR         0
`define HBSC_CTL_SW_LO         1
`define HBSC_CTL_SW_HI         12
`define HBSC_CTL_OL_CHECK_N    13
`define HBSC_CTL_SHORT_SEL     14
`define HBSC_CTL_RUN           15

// status word field positions
`define HBSC_ST_PREWARN        0
`define HBSC_ST_SW_LO          1
`define HBSC_ST_SW_HI          12
`define HBSC_ST_SHORT          13
`define HBSC_ST_STANDBY        14
`define HBSC_ST_SUPPLY         15

// reset value and overtemperature status word
`define HBSC_CTL_RESET         16'hE000
`define HBSC_ALL_ONES          16'hFFFF

// timing: clock rate and short-circuit shutdown delays
`define HBSC_CLK_MHZ           100
`define HBSC_T_SHORT_LONG_US   12000
`define HBSC_T_SHORT_SHORT_US  1500
`define HBSC_SHORT_LONG_CYC    (`HBSC_T_SHORT_LONG_US * `HBSC_CLK_MHZ)
`define HBSC_SHORT_SHORT_CYC   (`HBSC_T_SHORT_SHORT_US * `HBSC_CLK_MHZ)
`define HBSC_TMR_W             21

`endif

// *** verification/hbsc_host_model.sv ***
// hbsc_host_model.sv: host side of the serial link, behavioural.
// assumes pins change at the falling edge of clk_sys; link period 80 ns.
`timescale 1ns/1ps
module hbsc_host_model (
    // clock
    input wire   clk_sys,
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic serial_in,
    input wire   serial_out,
    input wire   serial_out_oe
);
    logic last_q;
    // a released data line reads as the inverse of its last value
    wire line = serial_out_oe ? serial_out : ~last_q;
    // idle: deselected, shift clock parked low
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        last_q = 1'b0;
    end
    // half a link clock period
    task automatic half;
        repeat (4) @(negedge clk_sys);
    endtask
    // one frame of nb bits, bit 0 first; rx gathers the device bits
    task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        @(negedge clk_sys);
        cs_n = 1'b0;
        half();
        for (i = 0; i < nb; i++) begin
            sclk = 1'b1;
            serial_in = tx[i];
            half();
            sclk = 1'b0;
            half();
            rx[i] = line;
            last_q = line;
        end
        cs_n = 1'b1;
        serial_in = ~serial_in;
        repeat (10) @(negedge clk_sys);
    endtask
endmodule

// *** verification/hbsc_top_properties.sv ***
// hbsc_top_properties.sv: port assertions for the serial control block.
// assumes a bind to hbsc_top; one clock domain, reset async low.
`timescale 1ns/1ps
module hbsc_top_properties #(
    parameter SHORT_LONG_CYC  = 40,
    parameter SHORT_SHORT_CYC = 10
) (
    // clock and reset
    input wire       clk_sys,
    input wire       arst_n,
    // link pins
    input wire       sclk,
    input wire       cs_n,
    input wire       serial_out,
    input wire       serial_out_oe,
    // standby and controls
    input wire       hard_standby_pin,
    input wire [5:0] low_side_on,
    input wire [5:0] high_side_on,
    input wire       open_load_check_n,
    input wire       short_delay_select,
    input wire       standby,
    input wire       status_clear_request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_oe_off_desel: assert property (cs_n [*5] |-> !serial_out_oe)
        else $error("data output driven while deselected");
    a_oe_on_select: assert property ($fell(cs_n) ##0 (!cs_n) [*6] |-> serial_out_oe)
        else $error("data output not enabled after select");
    a_oe_drop_end: assert property ($rose(cs_n) |-> ##[2:5] !serial_out_oe)
        else $error("data output still driven after frame end");
    a_ctl_hold_frame: assert property ((!cs_n) [*6] |->
        $stable(open_load_check_n) && $stable(short_delay_select))
        else $error("settings changed inside a frame");
    a_so_hold_low: assert property ((!sclk) [*2] ##0 (serial_out_oe && $past(serial_out_oe))
        |-> $stable(serial_out))
        else $error("data output moved without a shift clock rise");
    a_clear_one_cyc: assert property (status_clear_request |-> cs_n ##1 !status_clear_request)
        else $error("clear pulse inside frame or too long");
    a_pin_standby: assert property ((!hard_standby_pin) [*4] |-> standby)
        else $error("standby pin low but no standby");
    a_standby_off: assert property (standby [*2] |->
        low_side_on == 6'h00 && high_side_on == 6'h00)
        else $error("switch on during standby");
    a_reset_ctl: assert property ($rose(arst_n) |->
        open_load_check_n && short_delay_select && low_side_on == 6'h00)
        else $error("control word not at reset value");
endmodule
bind hbsc_top hbsc_top_properties #(
    .SHORT_LONG_CYC  (SHORT_LONG_CYC),
    .SHORT_SHORT_CYC (SHORT_SHORT_CYC)
) u_hbsc_top_properties (
    .clk_sys              (clk_sys),
    .arst_n               (arst_n),
    .sclk                 (sclk),
    .cs_n                 (cs_n),
    .serial_out           (serial_out),
    .serial_out_oe        (serial_out_oe),
    .hard_standby_pin     (hard_standby_pin),
    .low_side_on          (low_side_on),
    .high_side_on         (high_side_on),
    .open_load_check_n    (open_load_check_n),
    .short_delay_select   (short_delay_select),
    .standby              (standby),
    .status_clear_request (status_clear_request)
);

// *** verification/tb.sv ***
// tb.sv: self-checking bench of the half-bridge serial control block.
// assumes the host model drives the link; detectors driven from here.
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        hard_standby_pin = 1'b1;
    logic        temp_prewarn_in = 1'b0;
    logic        overtemp_in = 1'b0;
    logic        load_supply_low_in = 1'b0;
    logic [11:0] open_load_in = 12'h000;
    logic [11:0] current_limit_in = 12'h000;
    wire         sclk, cs_n, serial_in, serial_out, serial_out_oe;
    wire         open_load_check_n, short_delay_select, standby, status_clear_request;
    wire  [5:0]  low_side_on, high_side_on;
    wire  [15:0] outs = {1'b0, standby, short_delay_select, open_load_check_n,
                         high_side_on, low_side_on};
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n_pulse = 0;
    int          n_clr = 0;
    logic [15:0] ctl, rx, e;
    // clock
    always #5 clk_sys = ~clk_sys;
    // count clear pulses
    always @(posedge clk_sys) if (status_clear_request === 1'b1) n_pulse++;
    hbsc_top #(.SHORT_LONG_CYC(40), .SHORT_SHORT_CYC(10)) u_hbsc_top (
        .clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .hard_standby_pin(hard_standby_pin), .temp_prewarn_in(temp_prewarn_in),
        .overtemp_in(overtemp_in), .load_supply_low_in(load_supply_low_in),
        .open_load_in(open_load_in), .current_limit_in(current_limit_in),
        .low_side_on(low_side_on), .high_side_on(high_side_on),
        .open_load_check_n(open_load_check_n), .short_delay_select(short_delay_select),
        .standby(standby), .status_clear_request(status_clear_request));
    hbsc_host_model u_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    // expected status word from control word, detectors and flags
    function automatic logic [15:0] exp_st(input logic [15:0] c, input logic sc, input logic pf);
        logic sb;
        logic [11:0] d;
        sb = ~(c[15] & hard_standby_pin);
        d = sb ? 12'h000 : c[12:1];
        exp_st = {pf, sb, sc, c[13] ? d : (open_load_in & ~d), temp_prewarn_in};
    endfunction
    // expected control outputs from a control word
    function automatic logic [15:0] exp_out(input logic [15:0] c);
        logic sb;
        logic [11:0] d;
        sb = ~(c[15] & hard_standby_pin);
        d = sb ? 12'h000 : c[12:1];
        exp_out = {1'b0, sb, c[14], c[13], d[11], d[9], d[7], d[5], d[3], d[1],
                   d[10], d[8], d[6], d[4], d[2], d[0]};
    endfunction
    // compare one value
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    // full frame, status compared, control word remembered
    task automatic frame(input logic [15:0] tx, input logic [15:0] x);
        u_host.xfer(tx, 16, rx);
        chk("status", x, rx);
        n_clr += tx[0];
        ctl = tx;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // verdict
    task automatic report_and_stop;
        $display("TB: %0d compares, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
    // main sequence
    initial begin
        int i;
        wt(12);
        arst_n = 1'b1;
        void'($urandom(32'h5FB2CEE5));
        wt(6);
        ctl = 16'hE000;
        chk("controls", exp_out(ctl), outs);
        $display("TB: reset test done");
        for (i = 0; i < 12; i++) begin
            hard_standby_pin = ($urandom % 4) != 0;
            temp_prewarn_in = 1'($urandom);
            open_load_in = 12'($urandom);
            wt(4);
            frame(16'($urandom), exp_st(ctl, 1'b0, 1'b0));
            chk("controls", exp_out(ctl), outs);
        end
        hard_standby_pin = 1'b1;
        temp_prewarn_in = 1'b0;
        wt(4);
        frame(16'hE00A, exp_st(ctl, 1'b0, 1'b0));
        $display("TB: random test done");
        e = exp_st(ctl, 1'b0, 1'b0);
        u_host.xfer(~ctl, 8, rx);
        chk("short frame", e & 16'h00FF, rx);
        chk("controls", exp_out(ctl), outs);
        $display("TB: aborted frame test done");
        load_supply_low_in = 1'b1;
        wt(10);
        load_supply_low_in = 1'b0;
        wt(6);
        frame(ctl | 16'h0001, exp_st(ctl, 1'b0, 1'b1));
        frame(16'hE00A, exp_st(ctl, 1'b0, 1'b0));
        $display("TB: supply test done");
        current_limit_in = 12'h001;
        wt(25);
        chk("controls", exp_out(ctl), outs);
        wt(35);
        current_limit_in = 12'h000;
        wt(4);
        chk("controls", exp_out(ctl & 16'hFFFD), outs);
        frame(ctl | 16'h0001, exp_st(ctl & 16'hFFFD, 1'b1, 1'b0));
        chk("controls", exp_out(ctl), outs);
        frame(16'hA00A, exp_st(ctl, 1'b0, 1'b0));
        current_limit_in = 12'h001;
        wt(25);
        current_limit_in = 12'h000;
        wt(4);
        chk("controls", exp_out(ctl & 16'hFFFD), outs);
        frame(16'hE00B, exp_st(ctl & 16'hFFFD, 1'b1, 1'b0));
        chk("controls", exp_out(ctl), outs);
        $display("TB: short test done");
        overtemp_in = 1'b1;
        wt(10);
        frame(16'hE00A, 16'hFFFF);
        overtemp_in = 1'b0;
        wt(6);
        frame(ctl | 16'h0001, 16'hFFFF);
        frame(16'hE00A, exp_st(ctl, 1'b0, 1'b0));
        chk("clear pulses", 16'(n_clr), 16'(n_pulse));
        $display("TB: overtemperature test done");
        report_and_stop();
    end
endmodule
